// ===== core/adc_seq_pkg.sv
/*
 * constants, register map and carrier types of the conversion sequencer.
 * assumes a 32-bit classic wishbone register bus and an analog core on clk_i.
 */
package adc_seq_pkg;
    // --------------------
    // sizes
    // --------------------
    localparam int NCH   = 16;
    localparam int NPAIR = 8;
    localparam int NEXT  = 8;
    localparam int NIRQ  = 8;
    localparam int RES_W = 12;

    // --------------------
    // register map, byte offsets inside one converter's page
    // --------------------
    localparam int          CONV_BIT   = 8;
    localparam logic [1:0]  RGN_MISC   = 2'h0;
    localparam logic [1:0]  RGN_CTL    = 2'h1;
    localparam logic [1:0]  RGN_RES    = 2'h2;
    localparam logic [7:0]  OFS_PAIR   = 8'h00;
    localparam logic [7:0]  OFS_PRIO   = 8'h04;
    localparam logic [7:0]  OFS_ITS_LO = 8'h08;
    localparam logic [7:0]  OFS_ITS_HI = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_LO = 8'h10;
    localparam logic [7:0]  OFS_IRQ_HI = 8'h14;
    localparam logic [7:0]  OFS_STAT   = 8'h18;
    localparam logic [7:0]  OFS_CLR    = 8'h1C;
    localparam logic [31:0] CTL_MASK   = 32'h0000_1FFF;

    // --------------------
    // field codes
    // --------------------
    localparam logic [1:0] ITS_IRQ1       = 2'h1;
    localparam logic [1:0] ITS_IRQ2       = 2'h2;
    localparam int         IRQ_FIRST      = 0;
    localparam int         IRQ_SECOND     = 1;
    localparam logic [3:0] SEL_B_BASE     = 4'h6;
    localparam logic [3:0] GROUP_A_INPUTS = 4'h6;
    localparam logic [2:0] LOW_REFERENCE  = 3'h6;
    localparam logic [5:0] WIN_MIN_M1     = 6'h06;

    // --------------------
    // carriers
    // --------------------
    typedef struct packed {
        logic [18:0] rsvd;
        logic [5:0]  window;
        logic [2:0]  trig;
        logic [3:0]  sel;
    } channel_control_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       en;
        logic [3:0] ch;
    } irq_src_t;

    typedef struct packed {
        logic       sh_a;
        logic       sh_b;
        logic [2:0] sel_a;
        logic [2:0] sel_b;
        logic       start;
    } adc_req_t;

    typedef struct packed {
        logic             done;
        logic [RES_W-1:0] res_a;
        logic [RES_W-1:0] res_b;
    } adc_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10,
        ST_WRITE  = 2'b11
    } seq_state_t;
endpackage : adc_seq_pkg

// ===== core/adc_conversion_sequencer.sv
/*
 * conversion sequencer for two 12-bit converters with a wishbone slave.
 * assumes triggers and the analog core run on clk_i; results come with done.
 */
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
// Behaviour
// (RQ1) two converters, twelve-bit results each
// (RQ2) sixteen channels with own control, result
// (RQ3) pair bit n governs channels 2n, 2n+1
// (RQ4) sequential channel uses only own control
// (RQ5) simultaneous pair: even control, odd ignored
// (RQ6) pair shares trigger, window; two results
// (RQ7) any mix of single channels and pairs
// (RQ8) eight external triggers per converter
// (RQ9) two internal triggers from interrupts
// (RQ10) internal trigger select per channel
// (RQ11) trigger field picks external trigger
// (RQ12) one conversion at a time
// (RQ13) priority register orders pending channels
// (RQ14) group A mux picks six inputs
// (RQ15) group B adds low reference input
// (RQ16) sample-and-hold uses channel's window
// (RQ17) results open to all, config restricted
// (RQ18) channel completions routed to eight interrupts
// (RQ19) triggers latched pending until granted
// (RQ20) result written before its interrupt
`timescale 1ns/10ps
`default_nettype none

module conv_sequencer
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       tick_i,
    // configuration
    input  wire logic [NPAIR-1:0]           pair_mode_i,
    input  wire logic                       rr_i,
    input  wire logic [2*NCH-1:0]           its_i,
    input  wire irq_src_t [NIRQ-1:0]        irq_src_i,
    input  wire channel_control_t [NCH-1:0] ctl_i,
    // triggers and analog core
    input  wire logic [NEXT-1:0]            ext_trig_i,
    input  wire adc_rsp_t                   rsp_i,
    output adc_req_t                        req_o,
    // results and state
    output logic [NCH-1:0][RES_W-1:0]       res_o,
    output logic [NCH-1:0]                  pend_o,
    output logic                            busy_o,
    output logic [NIRQ-1:0]                 irq_o
);
    seq_state_t                st_q, st_d;
    logic [3:0]                ch_q, ch_d, last_q, last_d;
    logic                      sim_q, sim_d, grpb_q, grpb_d, busy_q, busy_d;
    logic [5:0]                cnt_q, cnt_d;
    logic [NEXT-1:0]           ext_prev_q;
    logic [NEXT-1:0]           ext_rise;
    logic [NCH-1:0]            pend_q, pend_d, hit, clr, odd_mask;
    logic [NIRQ-1:0]           irq_q, irq_d;
    adc_req_t                  req_q, req_d;
    logic [NCH-1:0][RES_W-1:0] res_q, res_d;
    logic [3:0]                pick, idx, start;
    logic                      found;
    channel_control_t          c;

    assign ext_rise = ext_trig_i & ~ext_prev_q;

    always_comb begin
        st_d   = st_q;
        ch_d   = ch_q;
        last_d = last_q;
        sim_d  = sim_q;
        grpb_d = grpb_q;
        cnt_d  = cnt_q;
        res_d  = res_q;
        req_d  = req_q;
        req_d.start = 1'b0;
        irq_d  = '0;
        clr    = '0;
        c      = ctl_i[0];
        // --------------------
        // trigger decode
        // --------------------
        for (int i = 0; i < NCH; i++) begin
            hit[i]      = 1'b0;
            // (RQ3) pair bit covers both
            odd_mask[i] = pair_mode_i[i/2] && (i % 2 == 1);
            if (!odd_mask[i]) begin
                // (RQ10) internal or external source
                case (its_i[2*i +: 2])
                    // (RQ9) interrupt driven trigger
                    ITS_IRQ1: hit[i] = irq_q[IRQ_FIRST];
                    ITS_IRQ2: hit[i] = irq_q[IRQ_SECOND];
                    // (RQ8) (RQ11) external trigger pick
                    default:  hit[i] = ext_rise[ctl_i[i].trig];
                endcase
            end
        end
        // --------------------
        // arbiter
        // --------------------
        // (RQ13) fixed or rotating order
        start = rr_i ? last_q + 4'h1 : 4'h0;
        found = 1'b0;
        pick  = start;
        for (int k = 0; k < NCH; k++) begin
            idx = start + 4'(k);
            if (!found && pend_q[idx]) begin
                found = 1'b1;
                pick  = idx;
            end
        end
        // --------------------
        // conversion sequence
        // --------------------
        case (st_q)
            // (RQ12) one conversion at a time
            ST_IDLE: begin
                if (found) begin
                    c        = ctl_i[pick];
                    ch_d     = pick;
                    last_d   = pick;
                    clr[pick] = 1'b1;
                    // (RQ7) mode per pair
                    sim_d    = pair_mode_i[pick/2];
                    grpb_d   = c.sel >= SEL_B_BASE;
                    // (RQ16) programmed sample window
                    cnt_d    = (c.window < WIN_MIN_M1) ? WIN_MIN_M1 : c.window;
                    req_d       = '0;
                    if (pair_mode_i[pick/2]) begin
                        // (RQ5) (RQ6) even control drives both
                        req_d.sel_a = (c.sel < GROUP_A_INPUTS) ? c.sel[2:0] : '0;
                        req_d.sel_b = (c.sel > 4'(LOW_REFERENCE)) ? LOW_REFERENCE
                                                                   : c.sel[2:0];
                        req_d.sh_a  = 1'b1;
                        req_d.sh_b  = 1'b1;
                    end else if (c.sel >= SEL_B_BASE) begin
                        // (RQ4) (RQ15) group B with low reference
                        req_d.sel_b = 3'(c.sel - SEL_B_BASE);
                        req_d.sh_b  = 1'b1;
                    end else begin
                        // (RQ14) group A input
                        req_d.sel_a = c.sel[2:0];
                        req_d.sh_a  = 1'b1;
                    end
                    st_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (tick_i) begin
                    if (cnt_q == '0) begin
                        req_d.sh_a  = 1'b0;
                        req_d.sh_b  = 1'b0;
                        req_d.start = 1'b1;
                        st_d        = ST_CONV;
                    end else begin
                        cnt_d = cnt_q - 6'h01;
                    end
                end
            end
            ST_CONV: begin
                if (rsp_i.done) begin
                    // (RQ2) (RQ6) results to own registers
                    if (sim_q) begin
                        res_d[ch_q]        = rsp_i.res_a;
                        res_d[ch_q | 4'h1] = rsp_i.res_b;
                    end else begin
                        res_d[ch_q] = grpb_q ? rsp_i.res_b : rsp_i.res_a;
                    end
                    st_d = ST_WRITE;
                end
            end
            ST_WRITE: begin
                // (RQ18) (RQ20) interrupt after result edge
                for (int j = 0; j < NIRQ; j++) begin
                    if (irq_src_i[j].en && (irq_src_i[j].ch == ch_q ||
                        (sim_q && irq_src_i[j].ch == (ch_q | 4'h1))))
                        irq_d[j] = 1'b1;
                end
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
        // (RQ19) new trigger wins over grant clear
        pend_d = (pend_q & ~clr & ~odd_mask) | hit;
        busy_d = st_d != ST_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q       <= ST_IDLE;
            ch_q       <= '0;
            last_q     <= '0;
            sim_q      <= 1'b0;
            grpb_q     <= 1'b0;
            busy_q     <= 1'b0;
            cnt_q      <= '0;
            ext_prev_q <= '0;
            pend_q     <= '0;
            irq_q      <= '0;
            req_q      <= '0;
            res_q      <= '0;
        end else begin
            st_q       <= st_d;
            ch_q       <= ch_d;
            last_q     <= last_d;
            sim_q      <= sim_d;
            grpb_q     <= grpb_d;
            busy_q     <= busy_d;
            cnt_q      <= cnt_d;
            ext_prev_q <= ext_trig_i;
            pend_q     <= pend_d;
            irq_q      <= irq_d;
            req_q      <= req_d;
            res_q      <= res_d;
        end
    end

    assign req_o  = req_q;
    assign res_o  = res_q;
    assign pend_o = pend_q;
    assign busy_o = busy_q;
    assign irq_o  = irq_q;
endmodule : conv_sequencer

module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int NCONV   = 2,
    parameter int ADC_DIV = 4
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [9:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    input  wire logic                        cfg_master_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    // converters
    input  wire logic [NCONV-1:0][NEXT-1:0]  ext_trig_i,
    input  wire adc_rsp_t [NCONV-1:0]        adc_rsp_i,
    output adc_req_t [NCONV-1:0]             adc_req_o,
    output logic [NCONV-1:0][NIRQ-1:0]       eoc_irq_o
);
    logic [NCONV-1:0][NPAIR-1:0]                pair_q, pair_d;
    logic [NCONV-1:0]                           prio_q, prio_d;
    logic [NCONV-1:0][2*NCH-1:0]                its_q, its_d;
    irq_src_t [NCONV-1:0][NIRQ-1:0]             isrc_q, isrc_d;
    channel_control_t [NCONV-1:0][NCH-1:0]      ctl_q, ctl_d;
    logic [NCONV-1:0][NIRQ-1:0]                 flag_q, flag_d, irq_w;
    logic [NCONV-1:0][NCH-1:0][RES_W-1:0]       res_w;
    logic [NCONV-1:0][NCH-1:0]                  pend_w;
    logic [NCONV-1:0]                           busy_w;
    logic [31:0]                                dat_q, dat_d, wv;
    logic                                       ack_q, ack_d, acc, wr;
    logic [$clog2(ADC_DIV)-1:0]                 div_q, div_d;
    logic                                       tick_q, tick_d;
    logic                                       cs;
    logic [7:0]                                 ofs;
    logic [3:0]                                 ri;

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (s[b]) r[8*b +: 8] = n[8*b +: 8];
        return r;
    endfunction : wmerge

    // --------------------
    // converters
    // --------------------
    // (RQ1) one sequencer per converter
    for (genvar g = 0; g < NCONV; g++) begin : g_conv
        conv_sequencer u_seq (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .tick_i      (tick_q),
            .pair_mode_i (pair_q[g]),
            .rr_i        (prio_q[g]),
            .its_i       (its_q[g]),
            .irq_src_i   (isrc_q[g]),
            .ctl_i       (ctl_q[g]),
            .ext_trig_i  (ext_trig_i[g]),
            .rsp_i       (adc_rsp_i[g]),
            .req_o       (adc_req_o[g]),
            .res_o       (res_w[g]),
            .pend_o      (pend_w[g]),
            .busy_o      (busy_w[g]),
            .irq_o       (irq_w[g])
        );
    end

    // --------------------
    // register file
    // --------------------
    always_comb begin
        acc    = wb_cyc_i && wb_stb_i && !ack_q;
        wr     = acc && wb_we_i && cfg_master_i;
        cs     = wb_adr_i[CONV_BIT] && (NCONV > 1);
        ofs    = wb_adr_i[7:0];
        ri     = ofs[5:2];
        ack_d  = acc;
        dat_d  = dat_q;
        pair_d = pair_q;
        prio_d = prio_q;
        its_d  = its_q;
        isrc_d = isrc_q;
        ctl_d  = ctl_q;
        div_d  = (div_q == $bits(div_q)'(ADC_DIV - 1)) ? '0 : div_q + 1'b1;
        tick_d = div_q == '0;
        wv     = '0;
        // sticky flags, a new event wins over the clear
        for (int v = 0; v < NCONV; v++) begin
            flag_d[v] = flag_q[v];
            if (wr && ofs == OFS_CLR && cs == v[0])
                flag_d[v] = flag_q[v] & ~wb_dat_i[NIRQ-1:0];
            flag_d[v] = flag_d[v] | irq_w[v];
        end
        if (acc) begin
            case (ofs[7:6])
                RGN_MISC: case (ofs)
                    OFS_PAIR:   wv = {24'h0, pair_q[cs]};
                    OFS_PRIO:   wv = {31'h0, prio_q[cs]};
                    OFS_ITS_LO: wv = {16'h0, its_q[cs][15:0]};
                    OFS_ITS_HI: wv = {16'h0, its_q[cs][31:16]};
                    OFS_IRQ_LO: wv = isrc_q[cs][3:0];
                    OFS_IRQ_HI: wv = isrc_q[cs][7:4];
                    OFS_STAT:   wv = {flag_q[cs], 7'h0, busy_w[cs], pend_w[cs]};
                    default:    wv = '0;
                endcase
                RGN_CTL: wv = ctl_q[cs][ri];
                RGN_RES: wv = {20'h0, res_w[cs][ri]};
                default: wv = '0;
            endcase
            // (RQ17) results open, configuration only to control side
            dat_d = (cfg_master_i || ofs[7:6] == RGN_RES) ? wv : '0;
            if (wr) begin
                wv = wmerge(wv, wb_dat_i, wb_sel_i);
                case (ofs[7:6])
                    RGN_MISC: case (ofs)
                        OFS_PAIR:   pair_d[cs] = wv[NPAIR-1:0];
                        OFS_PRIO:   prio_d[cs] = wv[0];
                        OFS_ITS_LO: its_d[cs][15:0] = wv[15:0];
                        OFS_ITS_HI: its_d[cs][31:16] = wv[15:0];
                        OFS_IRQ_LO: isrc_d[cs][3:0] = wv;
                        OFS_IRQ_HI: isrc_d[cs][7:4] = wv;
                        default: ;
                    endcase
                    RGN_CTL: ctl_d[cs][ri] = channel_control_t'(wv & CTL_MASK);
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pair_q <= '0;
            prio_q <= '0;
            its_q  <= '0;
            isrc_q <= '0;
            ctl_q  <= '0;
            flag_q <= '0;
            dat_q  <= '0;
            ack_q  <= 1'b0;
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            pair_q <= pair_d;
            prio_q <= prio_d;
            its_q  <= its_d;
            isrc_q <= isrc_d;
            ctl_q  <= ctl_d;
            flag_q <= flag_d;
            dat_q  <= dat_d;
            ack_q  <= ack_d;
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign wb_dat_o  = dat_q;
    assign wb_ack_o  = ack_q;
    assign eoc_irq_o = irq_w;
endmodule : adc_conversion_sequencer

`default_nettype wire

// ===== bench/adc_conversion_sequencer_sva.sv
/*
 * concurrent checks on the sequencer's top ports, converter 0 for timing.
 * assumes one clock, sync active-high reset, bound from the testbench.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_seq_sva
    import adc_seq_pkg::*;
#(
    parameter int NCONV   = 2,
    parameter int ADC_DIV = 4
) (
    // clock and reset
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    // wishbone
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [9:0]                 wb_adr_i,
    input wire logic                       cfg_master_i,
    input wire logic [31:0]                wb_dat_o,
    input wire logic                       wb_ack_o,
    // converters
    input wire adc_rsp_t [NCONV-1:0]       adc_rsp_i,
    input wire adc_req_t [NCONV-1:0]       adc_req_o,
    input wire logic [NCONV-1:0][NIRQ-1:0] eoc_irq_o
);
    // --------------------
    // helpers
    // --------------------
    wire logic sh0 = adc_req_o[0].sh_a | adc_req_o[0].sh_b;
    wire logic st0 = adc_req_o[0].start;
    logic [7:0] sh_cnt_q;
    always_ff @(posedge clk_i) begin
        sh_cnt_q <= (rst_i || !sh0) ? 8'h00 : sh_cnt_q + 8'h01;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // --------------------
    // assertions
    // --------------------
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_cfg_locked: assert property (wb_ack_o && !wb_we_i && !cfg_master_i
        && wb_adr_i[7:6] != RGN_RES |-> wb_dat_o == 32'h0000_0000)
        else $error("config read open to other side");
    a_result_width: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i[7:6] == RGN_RES |-> wb_dat_o[31:RES_W] == '0)
        else $error("result wider than twelve bits");
    a_start_sh_low: assert property (st0 |-> !sh0)
        else $error("start while sampling");
    a_sample_start: assert property ($fell(sh0) |-> ##[0:2] st0)
        else $error("no start after sampling window");
    a_window_min: assert property ($fell(sh0) |-> sh_cnt_q >= 8'(6*ADC_DIV))
        else $error("sampling window too short");
    a_one_conv: assert property (st0 |=> (!sh0 && !st0)[*3])
        else $error("second conversion overlaps");
    a_irq_after_done: assert property (|eoc_irq_o[0]
        |-> $past(adc_rsp_i[0].done, 1) || $past(adc_rsp_i[0].done, 2))
        else $error("interrupt without finished result");
    a_irq_pulse: assert property (|eoc_irq_o[0] |=> eoc_irq_o[0] == '0)
        else $error("interrupt longer than one cycle");
endmodule : adc_seq_sva
`default_nettype wire

// ===== bench/adc_core_model.sv
/*
 * behavioural analog core: keeps the selects seen while sampling and
 * answers a start with done after LAT cycles; results encode the inputs.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_core_model
    import adc_seq_pkg::*;
#(
    parameter int NCONV = 2,
    parameter int LAT   = 4
) (
    input  wire logic                 clk_i,
    input  wire adc_req_t [NCONV-1:0] req_i,
    output var adc_rsp_t [NCONV-1:0]  rsp_o
);
    adc_rsp_t [NCONV-1:0] rsp_q = '0;
    logic [2:0] sa [NCONV];
    logic [2:0] sb [NCONV];
    int         cnt [NCONV] = '{default: 0};
    assign rsp_o = rsp_q;
    // results outside done toggle so a stale sample never matches
    always @(posedge clk_i) begin
        for (int c = 0; c < NCONV; c++) begin
            rsp_q[c].done  <= 1'b0;
            rsp_q[c].res_a <= ~rsp_q[c].res_a;
            rsp_q[c].res_b <= ~rsp_q[c].res_b;
            if (req_i[c].sh_a) sa[c] <= req_i[c].sel_a;
            if (req_i[c].sh_b) sb[c] <= req_i[c].sel_b;
            if (req_i[c].start) cnt[c] <= LAT;
            else if (cnt[c] > 1) cnt[c] <= cnt[c] - 1;
            else if (cnt[c] == 1) begin
                cnt[c]         <= 0;
                rsp_q[c].done  <= 1'b1;
                rsp_q[c].res_a <= {4'hA, 4'(c), 1'b0, sa[c]};
                rsp_q[c].res_b <= {4'hB, 4'(c), 1'b0, sb[c]};
            end
        end
    end
endmodule : adc_core_model
`default_nettype wire

// ===== bench/adc_conversion_sequencer_tb.sv
/*
 * self-checking bench: wishbone master, trigger pulses, queued expectations.
 * assumes the analog core model answers done LAT cycles after start.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module adc_conversion_sequencer_tb;
    import adc_seq_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cfg = 1'b1;
    logic [9:0]       adr = '0, b;
    logic [3:0]       sel = '0;
    logic [31:0]      wdat = '0, rdat, er, v;
    logic [15:0]      ei;
    logic             ack;
    logic [1:0][7:0]  ext = '0, irq;
    adc_rsp_t [1:0]   rsp;
    adc_req_t [1:0]   req;
    logic [31:0]      rd_q [$];
    logic [15:0]      irq_q [$];
    int               err_total = 0, compares = 0, cyc_n = 0;
    always #5 clk_i = ~clk_i;
    adc_conversion_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .cfg_master_i(cfg), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_trig_i(ext), .adc_rsp_i(rsp), .adc_req_o(req), .eoc_irq_o(irq));
    adc_core_model u_core (.clk_i(clk_i), .req_i(req), .rsp_o(rsp));
    // --------------------
    // tasks
    // --------------------
    task print_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
              input logic [3:0] s = 4'hF);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task rd(input logic [9:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd
    task fire(input int c, input int n);
        ext[c][n] <= 1'b1;
        @(posedge clk_i);
        ext[c][n] <= 1'b0;
        @(posedge clk_i);
    endtask : fire
    task drain(input string s);
        while (irq_q.size() != 0) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        $display("test %s done", s);
    endtask : drain
    function automatic logic [31:0] ctl(logic [3:0] s, logic [2:0] t, logic [5:0] w);
        return {19'h0, w, t, s};
    endfunction : ctl
    function automatic logic [31:0] ra(int c, logic [2:0] s);
        return {20'h0, 4'hA, 4'(c), 1'b0, s};
    endfunction : ra
    function automatic logic [31:0] rb(int c, logic [2:0] s);
        return {20'h0, 4'hB, 4'(c), 1'b0, s};
    endfunction : rb
    // --------------------
    // monitor and timeout
    // --------------------
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            print_verdict;
        end
        if (ack === 1'b1 && we === 1'b0 && rd_q.size() != 0) begin
            er = rd_q.pop_front();
            `CHK("read data", er, rdat)
        end
        if (irq !== 16'h0000) begin
            ei = (irq_q.size() != 0) ? irq_q.pop_front() : 16'h0000;
            `CHK("eoc irq", ei, irq)
        end
    end
    // --------------------
    // main sequence
    // --------------------
    initial begin
        void'($urandom(32'hA6A022AE));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("req idle", 18'h00000, req)
        rd(10'h000, 32'h0); rd(10'h004, 32'h0); rd(10'h118, 32'h0); rd(10'h190, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 2; c++) begin
            b = 10'(c * 256);
            v = $urandom_range(0, 10);
            xfer(1'b1, b + 10'h050, ctl(4'h2, 3'h3, v[5:0]));
            xfer(1'b1, b + 10'h054, ctl(4'h8, 3'h5, v[5:0] + 6'h01));
            xfer(1'b1, b + 10'h010, 32'h0000_1514);
            irq_q.push_back(16'h0001 << (8 * c));
            fire(c, 3);
            drain("sequential first");
            irq_q.push_back(16'h0002 << (8 * c));
            fire(c, 5);
            drain("sequential second");
            rd(b + 10'h090, ra(c, 3'h2));
            rd(b + 10'h094, rb(c, 3'h2));
        end
        xfer(1'b1, 10'h01C, 32'h0000_00FF);
        xfer(1'b1, 10'h000, 32'h0000_0004);
        xfer(1'b1, 10'h050, ctl(4'h3, 3'h3, 6'h06));
        xfer(1'b1, 10'h054, ctl(4'h9, 3'h5, 6'h06));
        xfer(1'b1, 10'h010, 32'h0000_0014);
        fire(0, 5);
        repeat (3) @(posedge clk_i);
        rd(10'h018, 32'h0);
        irq_q.push_back(16'h0001);
        fire(0, 3);
        drain("simultaneous");
        rd(10'h090, ra(0, 3'h3));
        rd(10'h094, rb(0, 3'h3));
        xfer(1'b1, 10'h11C, 32'h0000_00FF);
        xfer(1'b1, 10'h140, ctl(4'h1, 3'h6, 6'h06));
        xfer(1'b1, 10'h144, ctl(4'h4, 3'h6, 6'h06));
        xfer(1'b1, 10'h110, 32'h0000_1110);
        irq_q.push_back(16'h0100);
        irq_q.push_back(16'h0200);
        fire(1, 6);
        rd(10'h118, 32'h0001_0002);
        drain("priority");
        rd(10'h180, ra(1, 3'h1));
        rd(10'h184, ra(1, 3'h4));
        xfer(1'b1, 10'h108, 32'h0000_0010);
        xfer(1'b1, 10'h148, ctl(4'h5, 3'h7, 6'h06));
        xfer(1'b1, 10'h110, 32'h0000_1210);
        irq_q.push_back(16'h0100);
        irq_q.push_back(16'h0200);
        fire(1, 6);
        drain("internal trigger");
        rd(10'h188, ra(1, 3'h5));
        v = $urandom;
        xfer(1'b1, 10'h000, v, v[11:8]);
        rd(10'h000, {24'h0, v[8] ? v[7:0] : 8'h04});
        cfg <= 1'b0;
        xfer(1'b1, 10'h100, 32'h0000_00FF);
        rd(10'h000, 32'h0);
        rd(10'h180, ra(1, 3'h1));
        cfg <= 1'b1;
        rd(10'h100, 32'h0);
        xfer(1'b1, 10'h180, 32'h0000_0FFF);
        rd(10'h180, ra(1, 3'h1));
        rd(10'h020, 32'h0);
        rd(10'h0C0, 32'h0);
        $display("test access done");
        print_verdict;
    end
endmodule : adc_conversion_sequencer_tb
bind adc_conversion_sequencer adc_seq_sva #(.NCONV(NCONV), .ADC_DIV(ADC_DIV)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .cfg_master_i(cfg_master_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_rsp_i(adc_rsp_i),
    .adc_req_o(adc_req_o), .eoc_irq_o(eoc_irq_o));
`default_nettype wire
